/* File: logic/sram_capture_pkg.sv */
// shared constants and carriers for the sram input capture front end
package sram_capture_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic [1:0] BURST_LOW_LSB = 2'h0;
    localparam logic MODE_LINEAR = 1'b0;

    typedef enum logic [1:0] {
        st_deselected,
        st_read,
        st_write
    } access_e;

    typedef struct packed {
        logic chip_select_first_n;
        logic chip_select_second;
        logic chip_select_third_n;
        logic write_n;
        logic advance_or_load;
        logic [LANES-1:0] byte_write_n;
        logic [ADDR_W-1:0] addr;
    } cmd_s;
endpackage

/* File: logic/burst_counter.sv */
// two-bit burst counter with linear or interleaved sequencing
`timescale 1ns/1ps
module burst_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic advance,
    input wire logic [1:0] seed,
    input wire logic linear_mode,
    output logic [1:0] low_bits,
    output logic [1:0] next_low_bits
);
    logic [1:0] start;
    logic [1:0] count;
    logic [1:0] next_start;
    logic [1:0] next_count;

    function automatic logic [1:0] burst_order(input logic [1:0] s, input logic [1:0] c,
        input logic lin);
        burst_order = lin ? s + c : s ^ c;
    endfunction

    always_comb
    begin
        next_start = start;
        next_count = count;
        if (load)
        begin
            next_start = seed;
            next_count = sram_capture_pkg::BURST_RESET;
        end
        else if (advance)
        begin
            next_count = count + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start <= sram_capture_pkg::BURST_RESET;
            count <= sram_capture_pkg::BURST_RESET;
        end
        else
        begin
            start <= next_start;
            count <= next_count;
        end
    end

    assign low_bits = burst_order(start, count,
        linear_mode == sram_capture_pkg::MODE_LINEAR);
    // next value lets the read port look ahead one edge
    assign next_low_bits = burst_order(next_start, next_count,
        linear_mode == sram_capture_pkg::MODE_LINEAR);
endmodule

/* File: logic/sync_sram_input_capture.sv */
// synchronous command capture, burst addressing and storage of a flow-through sram
`timescale 1ns/1ps
module sync_sram_input_capture #(
    parameter int ADDR_W = sram_capture_pkg::ADDR_W,
    parameter int LANES = sram_capture_pkg::LANES,
    parameter int LANE_W = sram_capture_pkg::LANE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_qualifier_n,
    input wire logic burst_mode,
    input wire sram_capture_pkg::cmd_s cmd,
    input wire logic [LANES*LANE_W-1:0] data_in,
    output logic [LANES*LANE_W-1:0] data_out,
    output logic data_out_en,
    output logic [ADDR_W-1:0] access_addr,
    output logic selected
);
    localparam int DATA_W = LANES * LANE_W;

    function automatic logic chip_sel(input sram_capture_pkg::cmd_s c);
        chip_sel = !c.chip_select_first_n && c.chip_select_second
                   && !c.chip_select_third_n;
    endfunction

    logic [DATA_W-1:0] read_word;
    logic [ADDR_W-1:0] read_addr;
    logic [1:0] next_low_bits;
    sram_capture_pkg::access_e state;
    sram_capture_pkg::access_e next_state;
    logic [ADDR_W-3:0] upper;
    logic [ADDR_W-3:0] next_upper;
    logic [LANES-1:0] lanes;
    logic [LANES-1:0] next_lanes;
    logic mode;
    logic next_mode;
    logic mode_caught;
    logic [1:0] low_bits;
    logic go;
    logic load;
    logic advance;
    logic [ADDR_W-1:0] addr_now;
    logic [DATA_W-1:0] next_data_out;
    logic next_data_out_en;

    assign go = !clock_qualifier_n;
    assign load = go && !cmd.advance_or_load && chip_sel(cmd);
    assign advance = go && cmd.advance_or_load && state != sram_capture_pkg::st_deselected;
    assign addr_now = {upper, low_bits};
    // address in effect after this edge
    assign read_addr = {next_upper, next_low_bits};

    burst_counter u_burst (
        .clk(clk),
        .rst_n(rst_n),
        .load(load),
        .advance(advance),
        .seed(cmd.addr[1:0]),
        .linear_mode(mode),
        .low_bits(low_bits),
        .next_low_bits(next_low_bits)
    );

    always_comb
    begin
        next_state = state;
        next_upper = upper;
        next_lanes = lanes;
        next_mode = mode;
        if (!mode_caught)
        begin
            next_mode = burst_mode;
        end
        if (go)
        begin
            if (!cmd.advance_or_load)
            begin
                if (chip_sel(cmd))
                begin
                    next_upper = cmd.addr[ADDR_W-1:2];
                    next_state = cmd.write_n ? sram_capture_pkg::st_read
                                             : sram_capture_pkg::st_write;
                    next_lanes = cmd.byte_write_n;
                end
                else
                begin
                    next_state = sram_capture_pkg::st_deselected;
                end
            end
            else if (state == sram_capture_pkg::st_write)
            begin
                next_lanes = cmd.byte_write_n;
            end
        end
    end

    // output word frozen on unqualified edge
    always_comb
    begin
        next_data_out = data_out;
        next_data_out_en = data_out_en;
        if (go)
        begin
            next_data_out_en = (next_state == sram_capture_pkg::st_read);
            if (next_state == sram_capture_pkg::st_read)
            begin
                // flow-through read of the new address
                next_data_out = read_word;
            end
        end
    end

    // per lane write on low strobe
    genvar i;
    generate
        for (i = 0; i < LANES; i++)
        begin : g_lane
            logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];

            always_ff @(posedge clk)
            begin
                if (go && state == sram_capture_pkg::st_write && !lanes[i])
                begin
                    lane_mem[addr_now] <= data_in[i*LANE_W +: LANE_W];
                end
            end

            // lane read of next access address
            assign read_word[i*LANE_W +: LANE_W] = lane_mem[read_addr];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= sram_capture_pkg::st_deselected;
            upper <= '0;
            lanes <= '1;
            mode <= 1'b1;
            mode_caught <= 1'b0;
            data_out <= '0;
            data_out_en <= 1'b0;
            access_addr <= '0;
            selected <= 1'b0;
        end
        else
        begin
            state <= next_state;
            upper <= next_upper;
            lanes <= next_lanes;
            mode <= next_mode;
            mode_caught <= 1'b1;
            data_out <= next_data_out;
            data_out_en <= next_data_out_en;
            access_addr <= addr_now;
            selected <= next_state != sram_capture_pkg::st_deselected;
        end
    end

    a_qual_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        clock_qualifier_n |=> $stable(state) && $stable(upper))
        else $error("state moved on unqualified edge");
    a_load_select: assert property (@(posedge clk) disable iff (!rst_n)
        go && !cmd.advance_or_load && !chip_sel(cmd) |=> !selected)
        else $error("deselect not taken");
    a_load_upper: assert property (@(posedge clk) disable iff (!rst_n)
        load |=> upper == $past(cmd.addr[ADDR_W-1:2]))
        else $error("upper address not captured");
    a_write_kind: assert property (@(posedge clk) disable iff (!rst_n)
        load && !cmd.write_n |=> state == sram_capture_pkg::st_write)
        else $error("write not started");
    a_read_kind: assert property (@(posedge clk) disable iff (!rst_n)
        load && cmd.write_n |=> data_out_en)
        else $error("read not driven");
    a_seed_low: assert property (@(posedge clk) disable iff (!rst_n)
        load |=> low_bits == $past(cmd.addr[1:0]))
        else $error("burst seed wrong");
    a_advance_move: assert property (@(posedge clk) disable iff (!rst_n)
        advance |=> low_bits != $past(low_bits) && upper == $past(upper))
        else $error("burst did not advance");
    a_wrap_four: assert property (@(posedge clk) disable iff (!rst_n)
        load ##1 (advance && !load) [*4] |=> low_bits == $past(low_bits, 4))
        else $error("burst did not wrap in four");
    a_load_fresh: assert property (@(posedge clk) disable iff (!rst_n)
        load |=> state != sram_capture_pkg::st_deselected)
        else $error("load did not select");
    a_lane_mask: assert property (@(posedge clk) disable iff (!rst_n)
        load && !cmd.write_n |=> lanes == $past(cmd.byte_write_n))
        else $error("lane strobes lost");
    a_mode_strap: assert property (@(posedge clk) disable iff (!rst_n)
        !mode_caught |=> mode == $past(burst_mode))
        else $error("strap not caught");
    a_frozen_data: assert property (@(posedge clk) disable iff (!rst_n)
        clock_qualifier_n |=> $stable(data_out) && $stable(data_out_en))
        else $error("read data moved on unqualified edge");
    a_deselect_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        go && !cmd.advance_or_load && !chip_sel(cmd) |=> !data_out_en)
        else $error("read driven while deselected");

    c_read: cover property (@(posedge clk) disable iff (!rst_n) load && cmd.write_n);
    c_write: cover property (@(posedge clk) disable iff (!rst_n) load && !cmd.write_n);
    c_burst: cover property (@(posedge clk) disable iff (!rst_n) load ##1 advance [*3]);
    c_stall: cover property (@(posedge clk) disable iff (!rst_n) load ##1 clock_qualifier_n);
    c_wrap: cover property (@(posedge clk) disable iff (!rst_n) load ##1 advance [*4]);
endmodule

/* File: verification/host_ctrl.sv */
// host controller model driving the command, data and qualifier pins
`timescale 1ns/1ps
module host_ctrl (
    input wire logic clk,
    output sram_capture_pkg::cmd_s cmd,
    output logic [35:0] data_in,
    output logic clock_qualifier_n
);
    initial
    begin
        cmd = '1;
        data_in = '0;
        clock_qualifier_n = 1'b1;
    end
    // whole command set once per cycle
    task automatic drive(input logic ld, input logic wr, input logic [1:0] cs,
        input logic [17:0] a, input logic [3:0] be, input logic dv, input logic [35:0] wd,
        input logic q);
        cmd.advance_or_load = !ld;
        cmd.write_n = !wr;
        cmd.chip_select_first_n = (cs == 2'h1);
        cmd.chip_select_second = (cs != 2'h2);
        cmd.chip_select_third_n = (cs == 2'h3);
        cmd.byte_write_n = be;
        cmd.addr = a;
        // data only in the data cycle
        data_in = dv ? wd : ~data_in;
        clock_qualifier_n = q;
    endtask
endmodule

/* File: verification/sync_sram_input_capture_tb.sv */
// self-checking bench for the sram input capture front end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module sync_sram_input_capture_tb;
    logic clk, rst_n, burst_mode, qn;
    sram_capture_pkg::cmd_s cmd;
    logic [35:0] data_in, data_out, exp_do;
    logic data_out_en, selected, sel, wr, pend, mode, ck;
    logic [35:0] mem [int];
    logic [17:0] base, pa, cur, access_addr;
    logic [3:0] pbe;
    int cnt;
    int miscompares = 0;
    int num_checks = 0;
    host_ctrl host (.clk(clk), .cmd(cmd), .data_in(data_in), .clock_qualifier_n(qn));
    sync_sram_input_capture dut (.clk(clk), .rst_n(rst_n), .clock_qualifier_n(qn),
        .burst_mode(burst_mode), .cmd(cmd), .data_in(data_in), .data_out(data_out),
        .data_out_en(data_out_en), .access_addr(access_addr), .selected(selected));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic model_edge();
        logic hz;
        logic [17:0] hpa;
        if (!rst_n || qn)
            return;
        hz = pend;
        hpa = pa;
        // lanes written where strobes are low
        if (pend)
            for (int i = 0; i < 4; i++)
                if (!pbe[i])
                    mem[pa][9*i +: 9] = data_in[9*i +: 9];
        pend = 1'b0;
        if (!cmd.advance_or_load)
        begin
            sel = !cmd.chip_select_first_n && cmd.chip_select_second
                && !cmd.chip_select_third_n;
            wr = !cmd.write_n;
            base = cmd.addr;
            cnt = 0;
        end
        else if (sel)
            cnt++;
        cur = {base[17:2], mode ? base[1:0] ^ 2'(cnt) : base[1:0] + 2'(cnt)};
        if (sel && wr)
        begin
            pend = 1'b1;
            pa = cur;
            pbe = cmd.byte_write_n;
        end
        ck = sel && !wr && mem.exists(cur) && !(hz && hpa == cur);
        if (ck)
            exp_do = mem[cur];
    endtask
    task automatic step(input logic ld, input logic w, input logic [1:0] cs,
        input logic [17:0] a, input logic [3:0] be, input logic q);
        logic ps;
        logic [17:0] pc;
        @(posedge clk);
        #1;
        ps = sel;
        pc = cur;
        model_edge();
        `CHK("selected", sel, selected)
        `CHK("data_out_en", sel && !wr, data_out_en)
        if (ck)
            `CHK("data_out", exp_do, data_out)
        if (ps)
            `CHK("access_addr", pc, access_addr)
        host.drive(ld || !sel, w, cs, a, be, pend, {4'($urandom), 32'($urandom)}, q);
    endtask
    task automatic do_reset(input logic m);
        @(posedge clk);
        #1;
        // the edge before reset still acts on the pins
        model_edge();
        rst_n = 1'b0;
        burst_mode = m;
        mode = m;
        sel = 1'b0;
        wr = 1'b0;
        pend = 1'b0;
        ck = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask
    task automatic traffic(input int n);
        logic ld;
        logic [1:0] cs;
        for (int k = 0; k < n; k++)
        begin
            ld = ($urandom % 3 == 0) || !sel;
            cs = ($urandom % 8 == 0) ? 2'($urandom % 3 + 1) : 2'h0;
            step(ld, 1'($urandom), cs, 18'($urandom) & 18'h3000f, 4'($urandom),
                ($urandom % 6 == 0));
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        burst_mode = 1'b0;
        void'($urandom(5027));
        for (int m = 0; m < 2; m++)
        begin
            do_reset(m[0]);
            for (int a = 0; a < 64; a++)
                step(1'b1, 1'b1, 2'h0, {a[5:4], 12'h0, a[3:0]}, 4'h0, 1'b0);
            traffic(400);
            $display("test burst mode %0d done", m);
        end
        close_out();
    end
    initial
    begin
        #40000;
        miscompares++;
        close_out();
    end
endmodule
